//--- src/sau_ctrl_pkg.sv
// Constants for the serial unit clock gate, prescaler and channel mode registers
package sau_ctrl_pkg;

  // ****************************************
  // Geometry
  // ****************************************
  localparam int          NUM_UNITS = 2;
  localparam int          NUM_CH    = 6;
  localparam int          ADDR_W    = 20;
  localparam int          DATA_W    = 16;
  localparam int          PRESC_W   = 11;
  localparam int          DIV_W     = 7;
  localparam logic [5:0]  CH_UNIT   = 6'h3C;  // Bit n set: channel n sits in unit 1

  // ****************************************
  // Register offsets
  // ****************************************
  localparam logic [19:0] ADDR_GATE    = 20'hF00F0;
  localparam logic [19:0] ADDR_PRESC0  = 20'hF0126;
  localparam logic [19:0] ADDR_PRESC1  = 20'hF0166;
  localparam logic [19:0] ADDR_MODE [NUM_CH] = '{20'hF0110, 20'hF0112, 20'hF0150,
                                                 20'hF0152, 20'hF0154, 20'hF0156};

  // ****************************************
  // Clock gate fields
  // ****************************************
  localparam int          GATE_UNIT0 = 2;
  localparam int          GATE_UNIT1 = 3;
  localparam logic [7:0]  GATE_RESET = 8'h00;
  localparam logic [7:0]  GATE_WMASK = 8'h3F;

  // ****************************************
  // Prescaler fields
  // ****************************************
  localparam int          PRESC_A_LSB   = 0;
  localparam int          PRESC_B_LSB   = 4;
  localparam logic [15:0] PRESC_RESET   = 16'h0000;
  localparam logic [15:0] PRESC_WMASK   = 16'h00FF;
  localparam logic [3:0]  PRESC_MAX_DIV = 4'hB;
  localparam logic [3:0]  PRESC_TIMER   = 4'hF;

  // ****************************************
  // Channel mode fields
  // ****************************************
  localparam int          MODE_CKS     = 15;
  localparam int          MODE_CCS     = 14;
  localparam int          MODE_STS     = 8;
  localparam int          MODE_SIS     = 6;
  localparam int          MODE_MD_LSB  = 1;
  localparam int          MODE_IRQ     = 0;
  localparam logic [15:0] MODE_RESET   = 16'h0020;
  localparam logic [15:0] MODE_WMASK   = 16'hC147;
  localparam logic [15:0] MODE_FIXED   = 16'h0020;
  localparam logic [1:0]  PROTO_UART   = 2'h1;

  // ****************************************
  // Timing
  // ****************************************
  localparam int          GATE_SETTLE_CYCLES = 4;

endpackage

//--- src/serial_unit_clock_mode_regs.sv
// Clock gate, prescaler and channel mode registers of a two-unit serial array
//
// Contract
// - Gate register bit 2 enables unit 0, bit 3 enables unit 1.
// - Disabled unit: clocks stopped, register writes blocked, unit held in reset.
// - Disabled unit: writes ignored, reads give reset defaults.
// - Gate register resets to zero; bits 7 and 6 stay zero.
// - Prescaler bits 3:0 pick clock A, bits 7:4 pick clock B.
// - Prescaler resets to zero, bits 15:8 zero, low byte writable alone.
// - Mode register resets to 0020H; only interrupt bit changes while running.
// - Clock-select bit picks prescaled clock A at 0, B at 1.
// - Transfer clock is divided operation clock, or serial clock pin when set.
// - Operation clock drives edge detector; transfer clock drives the shifter side.
// - Start trigger: software only, or receive pin edge, after start request.
// - Async mode: invert bit picks start edge polarity and data inversion.
// - Upper mode bits: 00 sync, 01 async, 10 two-wire master, 11 prohibited.
// - Lowest mode bit picks transfer-end or buffer-empty interrupt.
// - Divider value k gives operation clock divided by 2(k+1).
//
// Decided for this implementation: strobed register access.
`timescale 1ns/1ns
`default_nettype none

module serial_unit_clock_mode_regs
  import sau_ctrl_pkg::*;
(
  // Clock and reset
  input  wire logic                                         core_clk,
  input  wire logic                                         nrst,
  // Register port
  input  wire logic [sau_ctrl_pkg::ADDR_W-1:0]              regAddr,
  input  wire logic [sau_ctrl_pkg::DATA_W-1:0]              regWdata,
  input  wire logic                                         regWrite,
  input  wire logic                                         regByte,
  input  wire logic                                         regRead,
  output logic      [sau_ctrl_pkg::DATA_W-1:0]              regRdata,
  // Channel control from the rest of the unit
  input  wire logic [sau_ctrl_pkg::NUM_CH-1:0]              channelRunningFlag,
  input  wire logic [sau_ctrl_pkg::NUM_CH-1:0]              channelStartTrigger,
  input  wire logic [sau_ctrl_pkg::NUM_CH-1:0]              channelStopTrigger,
  input  wire logic [sau_ctrl_pkg::NUM_CH*sau_ctrl_pkg::DIV_W-1:0] channelDataDiv,
  input  wire logic                                         timerCh2IrqClock,
  // Pins
  input  wire logic [sau_ctrl_pkg::NUM_CH-1:0]              serialClockPin,
  input  wire logic [sau_ctrl_pkg::NUM_CH-1:0]              rxPin,
  // Unit outputs
  output logic      [sau_ctrl_pkg::NUM_UNITS-1:0]           unitClockEnable,
  output logic      [sau_ctrl_pkg::NUM_UNITS-1:0]           unitReset,
  output logic      [sau_ctrl_pkg::NUM_UNITS-1:0]           prescaledClockA,
  output logic      [sau_ctrl_pkg::NUM_UNITS-1:0]           prescaledClockB,
  // Channel outputs
  output logic      [sau_ctrl_pkg::NUM_CH-1:0]              opClockTick,
  output logic      [sau_ctrl_pkg::NUM_CH-1:0]              transferClock,
  output logic      [sau_ctrl_pkg::NUM_CH-1:0]              transferStart,
  output logic      [sau_ctrl_pkg::NUM_CH-1:0]              rxData,
  output logic      [sau_ctrl_pkg::NUM_CH*2-1:0]            protocolMode,
  output logic      [sau_ctrl_pkg::NUM_CH-1:0]              irqSourceSelect
);
  import sau_ctrl_pkg::*;

  // ****************************************
  // Helpers
  // ****************************************

  // Tick of a prescaled clock from the free counter and a 4-bit code
  function automatic logic prescTick(input logic [PRESC_W-1:0] cnt, input logic [3:0] code,
                                     input logic tmr, input logic isUnit0);
    logic [PRESC_W:0] lowMask;
    logic             hit;
    lowMask = ({{PRESC_W{1'b0}}, 1'b1} << code) - {{PRESC_W{1'b0}}, 1'b1};
    hit     = 1'b0;
    if (code == PRESC_TIMER) begin
      hit = tmr & isUnit0;
    end else if (code <= PRESC_MAX_DIV) begin
      hit = &(cnt | ~lowMask[PRESC_W-1:0]);
    end
    return hit;
  endfunction

  // Unit of a channel
  function automatic int chUnit(input int ch);
    return CH_UNIT[ch] ? 1 : 0;
  endfunction

  // ****************************************
  // Register file
  // ****************************************
  logic [7:0]        gateReg;
  logic [15:0]       prescReg      [NUM_UNITS];
  logic [15:0]       modeReg       [NUM_CH];
  logic [7:0]        next_gateReg;
  logic [15:0]       next_prescReg [NUM_UNITS];
  logic [15:0]       next_modeReg  [NUM_CH];
  logic [15:0]       next_regRdata;
  logic [NUM_UNITS-1:0] unitEn;

  assign unitEn = {gateReg[GATE_UNIT1], gateReg[GATE_UNIT0]};

  // Next register values from the write port
  always_comb begin
    next_gateReg = gateReg;
    if (regWrite && regAddr == ADDR_GATE) begin
      next_gateReg = regWdata[7:0] & GATE_WMASK;
    end
    for (int u = 0; u < NUM_UNITS; u++) begin
      next_prescReg[u] = prescReg[u];
      if (!unitEn[u]) begin
        next_prescReg[u] = PRESC_RESET;
      end else if (regWrite && regAddr == (u == 0 ? ADDR_PRESC0 : ADDR_PRESC1)) begin
        next_prescReg[u] = regWdata & PRESC_WMASK;
      end
    end
    for (int c = 0; c < NUM_CH; c++) begin
      next_modeReg[c] = modeReg[c];
      if (!unitEn[chUnit(c)]) begin
        next_modeReg[c] = MODE_RESET;
      end else if (regWrite && !regByte && regAddr == ADDR_MODE[c]) begin
        if (channelRunningFlag[c]) begin
          next_modeReg[c][MODE_IRQ] = regWdata[MODE_IRQ];
        end else begin
          next_modeReg[c] = (regWdata & MODE_WMASK) | MODE_FIXED;
        end
      end
    end
  end

  // Read data for the cycle after a read strobe
  always_comb begin
    next_regRdata = '0;
    if (regRead) begin
      if (regAddr == ADDR_GATE) begin
        next_regRdata = {8'h00, gateReg};
      end
      if (regAddr == ADDR_PRESC0) begin
        next_regRdata = prescReg[0];
      end
      if (regAddr == ADDR_PRESC1) begin
        next_regRdata = prescReg[1];
      end
      for (int c = 0; c < NUM_CH; c++) begin
        if (regAddr == ADDR_MODE[c]) begin
          next_regRdata = modeReg[c];
        end
      end
    end
  end

  // Register state
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      gateReg  <= GATE_RESET;
      regRdata <= 16'h0000;
      for (int u = 0; u < NUM_UNITS; u++) begin
        prescReg[u] <= PRESC_RESET;
      end
      for (int c = 0; c < NUM_CH; c++) begin
        modeReg[c] <= MODE_RESET;
      end
    end else begin
      gateReg  <= next_gateReg;
      regRdata <= next_regRdata;
      prescReg <= next_prescReg;
      modeReg  <= next_modeReg;
    end
  end

  // ****************************************
  // Unit prescalers
  // ****************************************
  logic [PRESC_W-1:0]   prescCnt      [NUM_UNITS];
  logic [PRESC_W-1:0]   next_prescCnt [NUM_UNITS];
  logic [NUM_UNITS-1:0] next_clkA;
  logic [NUM_UNITS-1:0] next_clkB;

  // Free counters stopped and cleared while a unit is gated off
  always_comb begin
    for (int u = 0; u < NUM_UNITS; u++) begin
      next_prescCnt[u] = unitEn[u] ? prescCnt[u] + 1'b1 : '0;
      next_clkA[u] = unitEn[u] & prescTick(prescCnt[u], prescReg[u][PRESC_A_LSB +: 4],
                                           timerCh2IrqClock, u == 0);
      next_clkB[u] = unitEn[u] & prescTick(prescCnt[u], prescReg[u][PRESC_B_LSB +: 4],
                                           timerCh2IrqClock, u == 0);
    end
  end

  // Prescaler state and unit outputs
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      prescaledClockA <= '0;
      prescaledClockB <= '0;
      unitClockEnable <= '0;
      unitReset       <= '1;
      for (int u = 0; u < NUM_UNITS; u++) begin
        prescCnt[u] <= '0;
      end
    end else begin
      prescaledClockA <= next_clkA;
      prescaledClockB <= next_clkB;
      unitClockEnable <= next_gateReg[GATE_UNIT1:GATE_UNIT0];
      unitReset       <= ~next_gateReg[GATE_UNIT1:GATE_UNIT0];
      prescCnt        <= next_prescCnt;
    end
  end

  // ****************************************
  // Channels
  // ****************************************
  for (genvar c = 0; c < NUM_CH; c++) begin : g_ch
    localparam int U = CH_UNIT[c] ? 1 : 0;
    logic [15:0]      mode;
    logic             opTick;
    logic [7:0]       divCnt;
    logic [7:0]       next_divCnt;
    logic [7:0]       divLimit;
    logic             sckPrev;
    logic             rxSample;
    logic             armed;
    logic             next_armed;
    logic             next_xfer;
    logic             next_start;
    logic             next_rxSample;
    logic             edgeSeen;
    logic             invert;

    assign mode     = modeReg[c];
    assign opTick   = mode[MODE_CKS] ? next_clkB[U] : next_clkA[U];
    assign divLimit = {channelDataDiv[c*DIV_W +: DIV_W], 1'b1};
    assign invert   = mode[MODE_SIS] && mode[MODE_MD_LSB +: 2] == PROTO_UART;

    // Transfer clock, start arming and receive edge detection
    always_comb begin
      next_divCnt   = divCnt;
      next_xfer     = 1'b0;
      next_rxSample = rxSample;
      edgeSeen      = 1'b0;
      if (mode[MODE_CCS]) begin
        next_xfer   = serialClockPin[c] & ~sckPrev;
        next_divCnt = '0;
      end else if (!channelRunningFlag[c]) begin
        next_divCnt = '0;
      end else if (opTick) begin
        next_divCnt = (divCnt >= divLimit) ? 8'h00 : divCnt + 8'h01;
        next_xfer   = divCnt >= divLimit;
      end
      if (opTick) begin
        next_rxSample = rxPin[c] ^ invert;
        edgeSeen      = rxSample & ~next_rxSample;
      end
      next_start = armed && (!mode[MODE_STS] || edgeSeen);
      next_armed = armed;
      if (next_start || channelStopTrigger[c] || !channelRunningFlag[c]) begin
        next_armed = 1'b0;
      end
      if (channelStartTrigger[c]) begin
        next_armed = 1'b1;
      end
    end

    // Channel state and outputs
    always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
        divCnt                 <= 8'h00;
        sckPrev                <= 1'b0;
        rxSample               <= 1'b1;
        armed                  <= 1'b0;
        opClockTick[c]         <= 1'b0;
        transferClock[c]       <= 1'b0;
        transferStart[c]       <= 1'b0;
        rxData[c]              <= 1'b1;
        protocolMode[c*2 +: 2] <= 2'h0;
        irqSourceSelect[c]     <= 1'b0;
      end else begin
        divCnt                 <= next_divCnt;
        sckPrev                <= serialClockPin[c];
        rxSample               <= next_rxSample;
        armed                  <= next_armed;
        opClockTick[c]         <= opTick;
        transferClock[c]       <= next_xfer;
        transferStart[c]       <= next_start;
        rxData[c]              <= next_rxSample;
        protocolMode[c*2 +: 2] <= mode[MODE_MD_LSB +: 2];
        irqSourceSelect[c]     <= mode[MODE_IRQ];
      end
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  chk_gate_top_zero: assert property (@(posedge core_clk) disable iff (!nrst)
    gateReg[7:6] == 2'h0) else $error("gate register top bits not zero");

  chk_disabled_defaults: assert property (@(posedge core_clk) disable iff (!nrst)
    !unitEn[0] |=> (prescReg[0] == PRESC_RESET && modeReg[0] == MODE_RESET)
      || unitEn[0]) else $error("disabled unit kept non-default state");

  chk_presc_upper_zero: assert property (@(posedge core_clk) disable iff (!nrst)
    prescReg[1][15:8] == 8'h00) else $error("prescaler upper byte not zero");

  chk_mode_running_hold: assert property (@(posedge core_clk) disable iff (!nrst)
    channelRunningFlag[0] && unitEn[0] && regWrite && !regByte && regAddr == ADDR_MODE[0]
    |=> modeReg[0][15:1] == $past(modeReg[0][15:1])
      && modeReg[0][0] == $past(regWdata[0])) else $error("running mode write leaked");

  chk_mode_bit5: assert property (@(posedge core_clk) disable iff (!nrst)
    modeReg[1][5] && modeReg[1][4:3] == 2'h0) else $error("mode fixed bits wrong");

  chk_read_latency: assert property (@(posedge core_clk) disable iff (!nrst)
    regRead && regAddr == ADDR_GATE |=> regRdata == {8'h00, $past(gateReg)})
    else $error("gate read data wrong");

  chk_code0_ticks: assert property (@(posedge core_clk) disable iff (!nrst)
    unitEn[0] && prescReg[0][3:0] == 4'h0 |=> prescaledClockA[0])
    else $error("undivided clock missed a tick");

  chk_ext_xfer: assert property (@(posedge core_clk) disable iff (!nrst)
    modeReg[0][MODE_CCS] && serialClockPin[0] && !g_ch[0].sckPrev |=> transferClock[0])
    else $error("external transfer clock edge lost");

  chk_sw_start: assert property (@(posedge core_clk) disable iff (!nrst)
    channelStartTrigger[0] && !modeReg[0][MODE_STS] && channelRunningFlag[0]
    ##1 channelRunningFlag[0] && !channelStopTrigger[0] |=> transferStart[0])
    else $error("software start not issued");

endmodule

`default_nettype wire

//--- test/tb_serial_unit_clock_mode_regs.sv
// Self-checking bench for the serial unit clock gate, prescaler and mode registers
`timescale 1ns/1ns
`default_nettype none

module tb_serial_unit_clock_mode_regs;
  import sau_ctrl_pkg::*;

  // ****************************************
  // Signals
  // ****************************************
  logic                    core_clk;
  logic                    nrst;
  logic [ADDR_W-1:0]       regAddr;
  logic [DATA_W-1:0]       regWdata;
  logic                    regWrite;
  logic                    regByte;
  logic                    regRead;
  logic [DATA_W-1:0]       regRdata;
  logic [NUM_CH-1:0]       runFlag;
  logic [NUM_CH-1:0]       startTrig;
  logic [NUM_CH*DIV_W-1:0] dataDiv;
  logic [NUM_CH-1:0]       rxPin;
  logic [NUM_CH-1:0]       sckPin;
  logic                    tmrTick;
  logic [NUM_UNITS-1:0]    unitClockEnable;
  logic [NUM_UNITS-1:0]    unitReset;
  logic [NUM_UNITS-1:0]    clkA;
  logic [NUM_UNITS-1:0]    clkB;
  logic [NUM_CH-1:0]       opClockTick;
  logic [NUM_CH-1:0]       transferClock;
  logic [NUM_CH-1:0]       transferStart;
  logic [NUM_CH-1:0]       rxData;
  logic [NUM_CH*2-1:0]     protocolMode;
  logic [NUM_CH-1:0]       irqSourceSelect;
  int                      errTotal;
  int                      comparisons;
  int                      cycles;

  serial_unit_clock_mode_regs DUT (
    .core_clk(core_clk), .nrst(nrst), .regAddr(regAddr), .regWdata(regWdata),
    .regWrite(regWrite), .regByte(regByte), .regRead(regRead), .regRdata(regRdata),
    .channelRunningFlag(runFlag), .channelStartTrigger(startTrig),
    .channelStopTrigger(6'h00), .channelDataDiv(dataDiv), .timerCh2IrqClock(tmrTick),
    .serialClockPin(sckPin), .rxPin(rxPin), .unitClockEnable(unitClockEnable),
    .unitReset(unitReset), .prescaledClockA(clkA), .prescaledClockB(clkB),
    .opClockTick(opClockTick), .transferClock(transferClock),
    .transferStart(transferStart), .rxData(rxData), .protocolMode(protocolMode),
    .irqSourceSelect(irqSourceSelect)
  );

  // Clock at 25 MHz
  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end

  // Hang guard
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 20000) begin
      errTotal++;
      giveVerdict();
    end
  end

  // ****************************************
  // Tasks
  // ****************************************
  task giveVerdict();
    $display("Counts: %0d comparisons, %0d mismatches", comparisons, errTotal);
    if (errTotal == 0 && comparisons > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task check(input string name, input logic [15:0] exp, input logic [15:0] got);
    comparisons++;
    if (got !== exp) begin
      errTotal++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask

  task wr(input logic [19:0] a, input logic [15:0] d, input logic b);
    @(posedge core_clk);
    regWrite <= 1'b1;
    regAddr  <= a;
    regWdata <= d;
    regByte  <= b;
    @(posedge core_clk);
    regWrite <= 1'b0;
    regByte  <= 1'b0;
  endtask

  task rd(input logic [19:0] a, input logic [15:0] exp, input string name);
    @(posedge core_clk);
    regRead <= 1'b1;
    regAddr <= a;
    @(posedge core_clk);
    regRead <= 1'b0;
    #1 check(name, exp, regRdata);
  endtask

  function automatic logic pick(input int s);
    case (s)
      0:       pick = clkA[0];
      1:       pick = clkB[0];
      2:       pick = opClockTick[0];
      3:       pick = transferClock[0];
      default: pick = clkA[1];
    endcase
  endfunction

  // Pulses of one output over 32 cycles after settling
  task count(input int s, input int exp, input string name);
    int c;
    c = 0;
    repeat (8) @(posedge core_clk);
    repeat (32) begin
      @(posedge core_clk);
      #1 c += int'(pick(s));
    end
    check(name, 16'(exp), 16'(c));
  endtask

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    nrst = 1'b0; regAddr = '0; regWdata = '0; regWrite = 1'b0; regByte = 1'b0;
    regRead = 1'b0; runFlag = '0; startTrig = '0; dataDiv = '0; rxPin = '0;
    sckPin = '0; tmrTick = 1'b0;
    errTotal = 0; comparisons = 0; cycles = 0;
    repeat (20) @(posedge core_clk);
    nrst <= 1'b1;
    rd(ADDR_GATE, 16'(GATE_RESET), "gate reset");
    rd(ADDR_PRESC0, PRESC_RESET, "prescaler reset");
    for (int i = 0; i < NUM_CH; i++) rd(ADDR_MODE[i], MODE_RESET, "mode reset");
    rd(20'hF0000, 16'h0000, "unmapped read");
    check("unit reset", 16'h0003, 16'(unitReset));
    $display("Test reset values done");
    wr(ADDR_PRESC0, 16'h0012, 1'b0);
    wr(ADDR_MODE[0], 16'h8020, 1'b0);
    rd(ADDR_PRESC0, 16'h0000, "gated prescaler");
    rd(ADDR_MODE[0], 16'h0020, "gated mode");
    wr(ADDR_GATE, 16'h00FF, 1'b0);
    rd(ADDR_GATE, 16'h003F, "gate upper bits");
    check("enables", 16'h0003, 16'(unitClockEnable));
    wr(ADDR_GATE, 16'h0008, 1'b0);
    #1 check("unit1 only", 16'h0009, 16'({unitClockEnable, unitReset}));
    wr(ADDR_GATE, 16'h000C, 1'b0);
    repeat (GATE_SETTLE_CYCLES) @(posedge core_clk);
    $display("Test clock gate done");
    wr(ADDR_PRESC1, 16'hFFFF, 1'b0);
    rd(ADDR_PRESC1, 16'h00FF, "prescaler upper byte");
    wr(ADDR_PRESC1, 16'hAB12, 1'b1);
    rd(ADDR_PRESC1, 16'h0012, "prescaler byte write");
    count(4, 8, "unit1 clock A code 2");
    wr(ADDR_PRESC0, 16'h0021, 1'b0);
    count(0, 16, "clock A code 1");
    count(1, 8, "clock B code 2");
    $display("Test prescaler done");
    wr(ADDR_MODE[0], 16'hFFFF, 1'b0);
    rd(ADDR_MODE[0], 16'hC167, "mode fixed bits");
    wr(ADDR_MODE[0], 16'h0000, 1'b1);
    rd(ADDR_MODE[0], 16'hC167, "mode byte write");
    count(2, 8, "op clock picks B");
    @(posedge core_clk) runFlag <= 6'h01;
    wr(ADDR_MODE[0], 16'h0000, 1'b0);
    rd(ADDR_MODE[0], 16'hC166, "mode while running");
    check("irq source", 16'h0000, 16'(irqSourceSelect[0]));
    @(posedge core_clk) runFlag <= 6'h00;
    $display("Test mode register done");
    wr(ADDR_PRESC0, 16'h00C0, 1'b0);
    count(0, 32, "clock A code 0");
    count(1, 0, "clock B code C");
    wr(ADDR_MODE[0], 16'h0020, 1'b0);
    @(posedge core_clk) begin
      runFlag <= 6'h01;
      dataDiv <= 42'h1;
    end
    count(3, 8, "transfer clock k 1");
    @(posedge core_clk) dataDiv <= '0;
    count(3, 16, "transfer clock k 0");
    @(posedge core_clk) startTrig <= 6'h01;
    @(posedge core_clk) startTrig <= 6'h00;
    @(posedge core_clk);
    #1 check("transfer start", 16'h0001, 16'(transferStart[0]));
    @(posedge core_clk) runFlag <= 6'h00;
    $display("Test clocks and start done");
    for (int m = 0; m < 3; m++) begin
      wr(ADDR_MODE[0], 16'h0020 | 16'(m << 1), 1'b0);
      repeat (2) @(posedge core_clk);
      #1 check("protocol", 16'(m), 16'(protocolMode[1:0]));
    end
    @(posedge core_clk) rxPin <= 6'h01;
    wr(ADDR_MODE[0], 16'h0062, 1'b0);
    repeat (4) @(posedge core_clk);
    #1 check("rx inverted", 16'h0000, 16'(rxData[0]));
    wr(ADDR_MODE[0], 16'h0022, 1'b0);
    repeat (4) @(posedge core_clk);
    #1 check("rx plain", 16'h0001, 16'(rxData[0]));
    $display("Test protocol and receive done");
    // Start on a receive edge, transfer clock from the pin, timer tick clock
    wr(ADDR_MODE[0], 16'h0122, 1'b0);
    @(posedge core_clk) begin
      runFlag   <= 6'h01;
      startTrig <= 6'h01;
    end
    @(posedge core_clk) startTrig <= 6'h00;
    @(posedge core_clk);
    #1 check("edge start idle", 16'h0000, 16'(transferStart[0]));
    @(posedge core_clk) rxPin <= 6'h00;
    @(posedge core_clk);
    #1 check("edge start", 16'h0001, 16'(transferStart[0]));
    @(posedge core_clk) runFlag <= 6'h00;
    wr(ADDR_MODE[0], 16'h4020, 1'b0);
    @(posedge core_clk) sckPin <= 6'h01;
    @(posedge core_clk);
    #1 check("pin transfer clock", 16'h0001, 16'(transferClock[0]));
    @(posedge core_clk) sckPin <= 6'h00;
    #1 check("pin clock single", 16'h0000, 16'(transferClock[0]));
    wr(ADDR_PRESC0, 16'h000F, 1'b0);
    @(posedge core_clk) tmrTick <= 1'b1;
    @(posedge core_clk) tmrTick <= 1'b0;
    #1 check("timer clock", 16'h0001, 16'(clkA[0]));
    @(posedge core_clk);
    #1 check("timer clock idle", 16'h0000, 16'(clkA[0]));
    $display("Test triggers done");
    wr(ADDR_GATE, 16'h0008, 1'b0);
    #1 check("unit0 held", 16'h0001, 16'(unitReset[0]));
    rd(ADDR_PRESC0, 16'h0000, "off prescaler");
    rd(ADDR_MODE[0], 16'h0020, "off mode");
    wr(ADDR_PRESC0, 16'h0055, 1'b0);
    wr(ADDR_GATE, 16'h000C, 1'b0);
    repeat (4) @(posedge core_clk);
    rd(ADDR_PRESC0, 16'h0000, "blocked write");
    $display("Test gate off done");
    giveVerdict();
  end

endmodule
`default_nettype wire
